// ==== hdl/pes_pkg.sv ====
`default_nettype none
package pes_pkg;

  // Register map, byte addresses on the APB bus.
  localparam logic [11:0] PES_CTRL_OFS = 12'h000;
  localparam logic [11:0] PES_STATUS_OFS = 12'h004;
  localparam logic [11:0] PES_CAUSE_OFS = 12'h008;
  localparam logic [11:0] PES_HITS_OFS = 12'h00c;

  // Control register field positions and reset value.
  localparam int PES_CTRL_SEL_LSB = 0;
  localparam int PES_CTRL_MASK_LSB = 8;
  localparam int PES_CTRL_EN_BIT = 16;
  localparam logic [31:0] PES_CTRL_RST = 32'h0000_0000;

  // Status register field positions.
  localparam int PES_STAT_INC_BIT = 0;
  localparam int PES_STAT_EMPTY_BIT = 1;
  localparam int PES_STAT_FULL_BIT = 2;
  localparam int PES_STAT_DEPTH_LSB = 8;

  // Event select codes.
  localparam logic [7:0] PES_EV_FLUSH = 8'h26;
  localparam logic [7:0] PES_EV_IDENT = 8'h27;
  localparam logic [7:0] PES_EV_NOT_HALTED = 8'h76;
  localparam logic [7:0] PES_EV_FETCH_STALL = 8'h87;
  localparam logic [7:0] PES_EV_RAS_HIT = 8'h88;
  localparam logic [7:0] PES_EV_RAS_OVF = 8'h89;
  localparam logic [7:0] PES_EV_RET_INSTR = 8'hc0;
  localparam logic [7:0] PES_EV_RET_UOP = 8'hc1;
  localparam logic [7:0] PES_EV_RET_BR = 8'hc2;
  localparam logic [7:0] PES_EV_RET_BR_MISP = 8'hc3;
  localparam logic [7:0] PES_EV_RET_TAKEN = 8'hc4;
  localparam logic [7:0] PES_EV_RET_TAKEN_MISP = 8'hc5;
  localparam logic [7:0] PES_EV_RET_FAR = 8'hc6;
  localparam logic [7:0] PES_EV_RESYNC = 8'hc7;
  localparam logic [7:0] PES_EV_NEAR_RET = 8'hc8;
  localparam logic [7:0] PES_EV_NEAR_RET_MISP = 8'hc9;
  localparam logic [7:0] PES_EV_IND_MISP = 8'hca;
  localparam logic [7:0] PES_EV_FP_CLASS = 8'hcb;
  localparam logic [7:0] PES_EV_INT_MASKED = 8'hcd;
  localparam logic [7:0] PES_EV_INT_MASKED_PEND = 8'hce;
  localparam logic [7:0] PES_EV_INT_TAKEN = 8'hcf;
  localparam logic [7:0] PES_EV_DEC_EMPTY = 8'hd0;
  localparam logic [7:0] PES_EV_STALL_ANY = 8'hd1;
  localparam logic [7:0] PES_EV_STALL_BR_ABORT = 8'hd2;
  localparam logic [7:0] PES_EV_STALL_SERIAL = 8'hd3;
  localparam logic [7:0] PES_EV_STALL_SEG = 8'hd4;
  localparam logic [7:0] PES_EV_STALL_ROB = 8'hd5;
  localparam logic [7:0] PES_EV_STALL_RS = 8'hd6;
  localparam logic [7:0] PES_EV_STALL_FPU = 8'hd7;
  localparam logic [7:0] PES_EV_STALL_LS = 8'hd8;
  localparam logic [7:0] PES_EV_STALL_QUIET = 8'hd9;
  localparam logic [7:0] PES_EV_STALL_FAR = 8'hda;

  // Instruction class qualifier bits for the class event.
  localparam int PES_FP_CLASSES = 4;
  localparam logic [7:0] PES_CLS_X87 = 8'h01;
  localparam logic [7:0] PES_CLS_MM_INT = 8'h02;
  localparam logic [7:0] PES_CLS_PACKED = 8'h04;
  localparam logic [7:0] PES_CLS_SCALAR = 8'h08;

  // Dispatch stall causes, in event code order from the branch abort cause up.
  localparam int PES_STALL_CAUSES = 9;

  // Per-cycle status from the pipeline, all on the core clock.
  typedef struct packed {
    logic fetch_stall;
    logic near_call;
    logic near_return;
    logic cache_line_flush_instr;
    logic processor_ident_instr;
    logic halt_state;
    logic stop_clock_request;
    logic ret_instr;
    logic ret_exc_int;
    logic ret_uop;
    logic ret_branch;
    logic ret_mispredict;
    logic ret_taken;
    logic ret_far;
    logic ret_resync;
    logic ret_near_return;
    logic ret_near_return_misp;
    logic ret_indirect_misp;
    logic [PES_FP_CLASSES-1:0] ret_fp_class;
    logic interrupt_enable_flag;
    logic interrupt_pending;
    logic hw_int_taken;
    logic decoder_empty;
    logic [PES_STALL_CAUSES-1:0] stall_cause;
  } pes_src_t;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pes_apb_req_t;

endpackage
`default_nettype wire

// ==== hdl/pes_mask_or.sv ====
`timescale 1ns/1ps
`default_nettype none
module pes_mask_or #(
  parameter int WIDTH = 4
) (
  input wire logic [WIDTH-1:0] cond,
  input wire logic [WIDTH-1:0] enable,
  output logic hit
);
  logic [WIDTH-1:0] gated;

  if (WIDTH < 1) begin : g_bad
    $error("pes_mask_or needs at least one condition.");
  end

  // Each condition passes only when its enable bit is set.
  for (genvar i = 0; i < WIDTH; i++) begin : g_gate
    assign gated[i] = cond[i] & enable[i];
  end

  // Enabled conditions merge into one hit; an all-zero enable gives none.
  assign hit = |gated;
endmodule // pes_mask_or
`default_nettype wire

// ==== hdl/pes_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Event 87h counts every cycle the instruction fetcher is stalled.
// - Event 88h counts near returns served from a non-empty return stack.
// - Event 89h counts calls overflowing the return stack; oldest entry dropped.
// - Events 26h and 27h count retired cache flush and identification instructions.
// - Event 76h counts clocks where the core is neither halted nor stop-clocked.
// - Event C0h counts retired instructions; each exception or interrupt counts once.
// - Event C1h counts all retired micro-operations of every origin.
// - Event C2h counts retired control-flow changes including exceptions and interrupts.
// - Event C3h counts mispredicted retired branches; far, exception, interrupt always count.
// - C4h counts retired taken branches with exceptions; C5h only mispredicted ones.
// - Event C6h counts retired far transfers, exceptions and interrupts.
// - Event C7h counts resync pipeline restarts.
// - C8h counts retired near returns; C9h those the predictor got wrong.
// - Event CAh counts retired indirect branches with mispredicted target.
// - Event CBh counts retired instructions of mask-enabled classes, one each.
// - Event CDh asserts every cycle the interrupt enable flag is clear.
// - Event CEh asserts while interrupts are masked and one is pending.
// - Event CFh counts hardware interrupts taken, never software interrupts.
// - Event D0h counts cycles where the decoder has nothing to dispatch.
// - Event D1h is the OR of stall causes D2h to DAh.
// - D2h branch abort drain, D3h serialization, D4h segment load stalls.
// - D5h reorder buffer, D6h reservation station, D7h FPU scheduler full stalls.
// - Event D8h counts dispatch stalls for a full load/store unit.
module pes_top #(
  parameter int RAS_DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire pes_pkg::pes_apb_req_t apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire pes_pkg::pes_src_t src,
  output logic count_inc
);
  import pes_pkg::*;

  localparam int DW = $clog2(RAS_DEPTH + 1);

  if (RAS_DEPTH < 1 || RAS_DEPTH > 255) begin : g_bad_depth
    $error("pes_top RAS_DEPTH must lie between 1 and 255.");
  end

  // Control and APB state.
  logic [7:0] sel_q, sel_d;
  logic [7:0] umask_q, umask_d;
  logic en_q, en_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  // Return stack occupancy tracker.
  logic [DW-1:0] depth_q, depth_d;
  logic ras_hit, ras_ovf;

  // Event selection state.
  logic inc_q, inc_d;
  logic [31:0] hits_q, hits_d;
  logic fp_hit, stall_any, ev_hit;

  // Access decode helpers.
  logic setup, access_done, addr_hit;

  assign setup = apb_req.psel & ~apb_req.penable;
  assign access_done = apb_req.psel & apb_req.penable & pready_q;
  assign addr_hit = (apb_req.paddr == PES_CTRL_OFS) || (apb_req.paddr == PES_STATUS_OFS) ||
                    (apb_req.paddr == PES_CAUSE_OFS) || (apb_req.paddr == PES_HITS_OFS);

  // Register writes take effect at the completing edge, per byte lane.
  always_comb begin
    sel_d = sel_q;
    umask_d = umask_q;
    en_d = en_q;
    if (access_done && apb_req.pwrite && apb_req.paddr == PES_CTRL_OFS) begin
      if (apb_req.pstrb[0]) begin
        sel_d = apb_req.pwdata[PES_CTRL_SEL_LSB +: 8];
      end
      if (apb_req.pstrb[1]) begin
        umask_d = apb_req.pwdata[PES_CTRL_MASK_LSB +: 8];
      end
      if (apb_req.pstrb[2]) begin
        en_d = apb_req.pwdata[PES_CTRL_EN_BIT];
      end
    end
  end

  // The answer is prepared during setup so the access phase needs no wait state.
  always_comb begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (setup) begin
      pready_d = 1'b1;
      pslverr_d = ~addr_hit;
      if (!apb_req.pwrite) begin
        unique case (apb_req.paddr)
          PES_CTRL_OFS: begin
            prdata_d[PES_CTRL_SEL_LSB +: 8] = sel_q;
            prdata_d[PES_CTRL_MASK_LSB +: 8] = umask_q;
            prdata_d[PES_CTRL_EN_BIT] = en_q;
          end
          PES_STATUS_OFS: begin
            prdata_d[PES_STAT_INC_BIT] = inc_q;
            prdata_d[PES_STAT_EMPTY_BIT] = (depth_q == '0);
            prdata_d[PES_STAT_FULL_BIT] = (depth_q == DW'(RAS_DEPTH));
            prdata_d[PES_STAT_DEPTH_LSB +: DW] = depth_q;
          end
          PES_CAUSE_OFS: begin
            prdata_d[PES_STALL_CAUSES-1:0] = src.stall_cause;
          end
          PES_HITS_OFS: begin
            prdata_d = hits_q;
          end
          default: begin
            prdata_d = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Return stack occupancy: a call at full depth keeps the stack full, which drops the oldest entry.
  always_comb begin
    depth_d = depth_q;
    ras_hit = src.near_return && (depth_q != '0);
    ras_ovf = src.near_call && (depth_q == DW'(RAS_DEPTH)) && !src.near_return;
    if (src.near_call && !src.near_return) begin
      if (depth_q != DW'(RAS_DEPTH)) begin
        depth_d = depth_q + DW'(1);
      end
    end else if (src.near_return && !src.near_call) begin
      if (depth_q != '0) begin
        depth_d = depth_q - DW'(1);
      end
    end
  end

  // Net dispatch stall is a plain OR, so overlapping causes count once.
  assign stall_any = |src.stall_cause;

  // Class qualifier for the retired floating point and SIMD event.
  pes_mask_or #(
    .WIDTH(PES_FP_CLASSES)
  ) u_fp_mask (
    .cond(src.ret_fp_class),
    .enable(umask_q[PES_FP_CLASSES-1:0]),
    .hit(fp_hit)
  );

  // Select the condition for the chosen event; unknown codes never count.
  always_comb begin
    ev_hit = 1'b0;
    unique case (sel_q)
      PES_EV_FETCH_STALL: ev_hit = src.fetch_stall;
      PES_EV_RAS_HIT: ev_hit = ras_hit;
      PES_EV_RAS_OVF: ev_hit = ras_ovf;
      PES_EV_FLUSH: ev_hit = src.cache_line_flush_instr;
      PES_EV_IDENT: ev_hit = src.processor_ident_instr;
      PES_EV_NOT_HALTED: ev_hit = ~(src.halt_state | src.stop_clock_request);
      PES_EV_RET_INSTR: ev_hit = src.ret_instr | src.ret_exc_int;
      PES_EV_RET_UOP: ev_hit = src.ret_uop;
      PES_EV_RET_BR: ev_hit = src.ret_branch | src.ret_far | src.ret_exc_int;
      PES_EV_RET_BR_MISP: begin
        ev_hit = (src.ret_branch & src.ret_mispredict) | src.ret_far | src.ret_exc_int;
      end
      PES_EV_RET_TAKEN: ev_hit = src.ret_taken | src.ret_exc_int;
      PES_EV_RET_TAKEN_MISP: ev_hit = src.ret_taken & src.ret_mispredict;
      PES_EV_RET_FAR: ev_hit = src.ret_far | src.ret_exc_int;
      PES_EV_RESYNC: ev_hit = src.ret_resync;
      PES_EV_NEAR_RET: ev_hit = src.ret_near_return;
      PES_EV_NEAR_RET_MISP: ev_hit = src.ret_near_return & src.ret_near_return_misp;
      PES_EV_IND_MISP: ev_hit = src.ret_indirect_misp;
      PES_EV_FP_CLASS: ev_hit = fp_hit;
      PES_EV_INT_MASKED: ev_hit = ~src.interrupt_enable_flag;
      PES_EV_INT_MASKED_PEND: ev_hit = ~src.interrupt_enable_flag & src.interrupt_pending;
      PES_EV_INT_TAKEN: ev_hit = src.hw_int_taken;
      PES_EV_DEC_EMPTY: ev_hit = src.decoder_empty;
      PES_EV_STALL_ANY: ev_hit = stall_any;
      PES_EV_STALL_BR_ABORT: ev_hit = src.stall_cause[0];
      PES_EV_STALL_SERIAL: ev_hit = src.stall_cause[1];
      PES_EV_STALL_SEG: ev_hit = src.stall_cause[2];
      PES_EV_STALL_ROB: ev_hit = src.stall_cause[3];
      PES_EV_STALL_RS: ev_hit = src.stall_cause[4];
      PES_EV_STALL_FPU: ev_hit = src.stall_cause[5];
      PES_EV_STALL_LS: ev_hit = src.stall_cause[6];
      PES_EV_STALL_QUIET: ev_hit = src.stall_cause[7];
      PES_EV_STALL_FAR: ev_hit = src.stall_cause[8];
      default: ev_hit = 1'b0;
    endcase
  end

  // One increment per cycle at most, and a tally that software can read back.
  always_comb begin
    inc_d = en_q & ev_hit;
    hits_d = hits_q;
    if (access_done && apb_req.pwrite && apb_req.paddr == PES_HITS_OFS) begin
      hits_d = 32'h0000_0000;
    end else if (inc_q) begin
      hits_d = hits_q + 32'h0000_0001;
    end
  end

  // All state registers, cleared by the synchronous reset.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sel_q <= PES_CTRL_RST[PES_CTRL_SEL_LSB +: 8];
      umask_q <= PES_CTRL_RST[PES_CTRL_MASK_LSB +: 8];
      en_q <= PES_CTRL_RST[PES_CTRL_EN_BIT];
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      depth_q <= '0;
      inc_q <= 1'b0;
      hits_q <= 32'h0000_0000;
    end else begin
      sel_q <= sel_d;
      umask_q <= umask_d;
      en_q <= en_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      depth_q <= depth_d;
      inc_q <= inc_d;
      hits_q <= hits_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign count_inc = inc_q;
endmodule // pes_top
`default_nettype wire

// ==== sim/pes_top_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module pes_top_chk #(
  parameter int RAS_DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire pes_pkg::pes_apb_req_t apb_req,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire pes_pkg::pes_src_t src,
  input wire logic count_inc
);
  import pes_pkg::*;
  logic [16:0] ctrl_q;
  logic [16:0] ctrl_d;
  // Shadow of the control word, following completed writes lane by lane.
  always_comb begin
    ctrl_d = ctrl_q;
    if (apb_req.psel && apb_req.penable && pready && apb_req.pwrite && apb_req.paddr == PES_CTRL_OFS) begin
      if (apb_req.pstrb[0]) ctrl_d[7:0] = apb_req.pwdata[7:0];
      if (apb_req.pstrb[1]) ctrl_d[15:8] = apb_req.pwdata[15:8];
      if (apb_req.pstrb[2]) ctrl_d[16] = apb_req.pwdata[16];
    end
  end
  // The shadow clears with the design so no stale selection survives reset.
  always_ff @(posedge clock) begin
    if (!reset_n) ctrl_q <= '0;
    else ctrl_q <= ctrl_d;
  end
  // The control word is an argument, so assertions see its sampled value and not the updated one.
  function automatic logic sel_is(input logic [16:0] w, input logic [7:0] c);
    return w[16] && w[7:0] == c;
  endfunction
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  fetch_stall_a: assert property (sel_is(ctrl_q, PES_EV_FETCH_STALL) && src.fetch_stall |=> count_inc)
    else $error("fetch stall cycle not counted");
  flush_count_a: assert property (sel_is(ctrl_q, PES_EV_FLUSH) && src.cache_line_flush_instr |=> count_inc)
    else $error("flush retirement not counted");
  not_halted_a: assert property (sel_is(ctrl_q, PES_EV_NOT_HALTED) |=>
    count_inc == !($past(src.halt_state) || $past(src.stop_clock_request))) else $error("unhalted clock wrong");
  exc_misp_a: assert property (sel_is(ctrl_q, PES_EV_RET_BR_MISP) && src.ret_exc_int |=> count_inc)
    else $error("exception not counted as mispredict");
  taken_misp_a: assert property (sel_is(ctrl_q, PES_EV_RET_TAKEN_MISP) |=>
    count_inc == ($past(src.ret_taken) && $past(src.ret_mispredict))) else $error("taken mispredict wrong");
  if_clear_a: assert property (sel_is(ctrl_q, PES_EV_INT_MASKED) && !src.interrupt_enable_flag |=> count_inc)
    else $error("masked cycle not counted");
  mask_pend_a: assert property (sel_is(ctrl_q, PES_EV_INT_MASKED_PEND) |=>
    count_inc == (!$past(src.interrupt_enable_flag) && $past(src.interrupt_pending))) else $error("pending wrong");
  stall_any_a: assert property (sel_is(ctrl_q, PES_EV_STALL_ANY) |=> count_inc == |$past(src.stall_cause))
    else $error("net stall is not the or of causes");
  idle_none_a: assert property (!ctrl_q[16] |=> !count_inc)
    else $error("pulse while disabled");
  class_none_a: assert property (sel_is(ctrl_q, PES_EV_FP_CLASS) && ctrl_q[11:8] == 4'h0 |=> !count_inc)
    else $error("pulse with empty class mask");
  cover property (sel_is(ctrl_q, PES_EV_STALL_ANY) && count_inc);
  cover property (sel_is(ctrl_q, PES_EV_RAS_OVF) ##1 count_inc);
  cover property (sel_is(ctrl_q, PES_EV_FP_CLASS) && count_inc);
endmodule // pes_top_chk
bind pes_top pes_top_chk #(.RAS_DEPTH(RAS_DEPTH)) chk (.clock(clock), .reset_n(reset_n), .apb_req(apb_req),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .src(src), .count_inc(count_inc));
`default_nettype wire

// ==== sim/pes_pipe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pes_pipe_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic count_inc,
  output logic [15:0] tally_q
);
  logic [15:0] tally_d;
  // The far counter adds one for every increment pulse it sees.
  always_comb tally_d = count_inc ? tally_q + 16'h0001 : tally_q;
  // The tally clears with the core reset, like the design.
  always_ff @(posedge clock) begin
    if (!reset_n) tally_q <= '0;
    else tally_q <= tally_d;
  end
endmodule // pes_pipe_model
`default_nettype wire

// ==== sim/pes_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pes_top_test;
  import pes_pkg::*;
  logic clock, reset_n, pready, pslverr, count_inc;
  logic [31:0] prdata;
  logic [15:0] tally_q;
  pes_apb_req_t req;
  pes_src_t src, base;
  int error_cnt = 0;
  int n_compared = 0;
  pes_top #(.RAS_DEPTH(2)) uut (.clock(clock), .reset_n(reset_n), .apb_req(req), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .src(src), .count_inc(count_inc));
  pes_pipe_model far (.clock(clock), .reset_n(reset_n), .count_inc(count_inc), .tally_q(tally_q));
  // Free-running core clock.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task wrap_up();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer: setup, then access held until pready is seen high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clock);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: pready %h expected %h", $time, pready, 1'b1);
      wrap_up();
    end
    // One idle edge, so the next setup never reassigns psel in this time step.
    @(posedge clock);
  endtask
  // Select an event, drive a status toggle against the idle pattern, check far tally and hit count.
  task ev(input logic [7:0] sel, input logic [7:0] msk, input pes_src_t s, input int n, input logic [15:0] exp);
    logic [31:0] r;
    logic e;
    logic [15:0] t0;
    apb(1'b1, PES_CTRL_OFS, {15'h0, 1'b1, msk, sel}, r, e);
    apb(1'b1, PES_HITS_OFS, 32'h0, r, e);
    t0 = tally_q;
    src <= s ^ base;
    repeat (n) @(posedge clock);
    src <= base;
    repeat (3) @(posedge clock);
    cmp({16'h0, tally_q - t0}, {16'h0, exp});
    apb(1'b0, PES_HITS_OFS, 32'h0, r, e);
    cmp(r, {16'h0, exp});
  endtask
  // Main sequence; the idle pattern is halted with interrupts enabled, so no event fires at rest.
  initial begin
    logic [31:0] r;
    logic e;
    pes_src_t s;
    base = '0;
    base.halt_state = 1'b1;
    base.interrupt_enable_flag = 1'b1;
    src = base;
    req = '0;
    req.pstrb = 4'hf;
    reset_n = 1'b0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, PES_CTRL_OFS, 32'h0, r, e);
    cmp(r, PES_CTRL_RST);
    apb(1'b0, 12'h010, 32'h0, r, e);
    cmp({31'h0, e}, 32'h1);
    cmp(r, 32'h0);
    ev(PES_EV_FETCH_STALL, 8'h00, '{fetch_stall: 1'b1, default: '0}, 3, 3);
    apb(1'b0, PES_CTRL_OFS, 32'h0, r, e);
    cmp(r, {15'h0, 1'b1, 8'h00, PES_EV_FETCH_STALL});
    ev(PES_EV_RAS_OVF, 8'h00, '{near_call: 1'b1, default: '0}, 4, 2);
    apb(1'b0, PES_STATUS_OFS, 32'h0, r, e);
    cmp(r & 32'h0000_ff06, 32'h0000_0204);
    ev(PES_EV_RAS_HIT, 8'h00, '{near_return: 1'b1, default: '0}, 3, 2);
    ev(PES_EV_FLUSH, 8'h00, '{cache_line_flush_instr: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_IDENT, 8'h00, '{processor_ident_instr: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_NOT_HALTED, 8'h00, '{halt_state: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_NOT_HALTED, 8'h00, '{halt_state: 1'b1, stop_clock_request: 1'b1, default: '0}, 3, 0);
    ev(PES_EV_RET_INSTR, 8'h00, '{ret_exc_int: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_RET_UOP, 8'h00, '{ret_uop: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_RET_BR, 8'h00, '{ret_exc_int: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_RET_BR_MISP, 8'h00, '{ret_branch: 1'b1, default: '0}, 3, 0);
    ev(PES_EV_RET_BR_MISP, 8'h00, '{ret_far: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_RET_BR_MISP, 8'h00, '{ret_exc_int: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_RET_TAKEN, 8'h00, '{ret_exc_int: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_RET_TAKEN_MISP, 8'h00, '{ret_taken: 1'b1, default: '0}, 3, 0);
    ev(PES_EV_RET_TAKEN_MISP, 8'h00, '{ret_taken: 1'b1, ret_mispredict: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_RET_FAR, 8'h00, '{ret_far: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_RESYNC, 8'h00, '{ret_resync: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_NEAR_RET, 8'h00, '{ret_near_return: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_NEAR_RET_MISP, 8'h00, '{ret_near_return: 1'b1, default: '0}, 3, 0);
    ev(PES_EV_NEAR_RET_MISP, 8'h00, '{ret_near_return: 1'b1, ret_near_return_misp: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_IND_MISP, 8'h00, '{ret_indirect_misp: 1'b1, default: '0}, 3, 3);
    for (int i = 0; i < PES_FP_CLASSES; i++) begin
      s = '0;
      s.ret_fp_class[i] = 1'b1;
      ev(PES_EV_FP_CLASS, PES_CLS_X87 << i, s, 3, 3);
      ev(PES_EV_FP_CLASS, 8'h0f ^ (PES_CLS_X87 << i), s, 3, 0);
    end
    ev(PES_EV_FP_CLASS, 8'h00, '{ret_fp_class: 4'hf, default: '0}, 3, 0);
    ev(PES_EV_INT_MASKED, 8'h00, '{interrupt_enable_flag: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_INT_MASKED_PEND, 8'h00, '{interrupt_enable_flag: 1'b1, default: '0}, 3, 0);
    ev(PES_EV_INT_MASKED_PEND, 8'h00, '{interrupt_enable_flag: 1'b1, interrupt_pending: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_INT_TAKEN, 8'h00, '{hw_int_taken: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_DEC_EMPTY, 8'h00, '{decoder_empty: 1'b1, default: '0}, 3, 3);
    ev(PES_EV_STALL_ANY, 8'h00, '{stall_cause: 9'h038, default: '0}, 3, 3);
    for (int i = 0; i < PES_STALL_CAUSES; i++) begin
      s = '0;
      s.stall_cause[i] = 1'b1;
      ev(PES_EV_STALL_BR_ABORT + 8'(i), 8'h00, s, 3, 3);
    end
    ev(8'h00, 8'hff, '1, 3, 0);
    // With the enable bit clear, an active event must not reach the counter.
    apb(1'b1, PES_CTRL_OFS, {16'h0, 8'h00, PES_EV_FETCH_STALL}, r, e);
    apb(1'b1, PES_HITS_OFS, 32'h0, r, e);
    s = base;
    s.fetch_stall = 1'b1;
    src <= s;
    repeat (3) @(posedge clock);
    src <= base;
    repeat (3) @(posedge clock);
    apb(1'b0, PES_HITS_OFS, 32'h0, r, e);
    cmp(r, 32'h0);
    wrap_up();
  end
endmodule // pes_top_test
`default_nettype wire
